// ---- pkg/fdfc_pkg.sv ----
package fdfc_pkg;
  // register select codes
  localparam logic [1:0] SEL_CMD_STAT = 2'h0;
  localparam logic [1:0] SEL_TRACK = 2'h1;
  localparam logic [1:0] SEL_SECTOR = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;
  // reset values
  localparam logic [7:0] CMD_RESET_VAL = 8'h03;
  localparam logic [7:0] SECTOR_RESET_VAL = 8'h01;
  localparam logic [7:0] TRACK_RESET_VAL = 8'h00;
  localparam logic [7:0] DATA_RESET_VAL = 8'h00;
  // command opcodes (upper nibble) and flag positions
  localparam logic [3:0] OP_RESTORE = 4'h0;
  localparam logic [3:0] OP_SEEK = 4'h1;
  localparam logic [3:0] OP_FORCE_INT = 4'hd;
  localparam int CMD_UPDATE_BIT = 4;
  localparam int CMD_VERIFY_BIT = 2;
  localparam int CMD_SETTLE_BIT = 2;
  localparam int CMD_WRITE_BIT = 5;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DRQ = 1;
  localparam int ST_INDEX = 1;
  localparam int ST_LOST = 2;
  localparam int ST_TRK0 = 2;
  localparam int ST_CRC = 3;
  localparam int ST_SEEK = 4;
  // field marks and crc
  localparam logic [7:0] MARK_ID = 8'hfe;
  localparam logic [7:0] MARK_DATA = 8'hfb;
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [10:0] ID_LAST = 11'h005;
  localparam logic [10:0] SECTOR_BASE = 11'h080;
  localparam logic [2:0] VERIFY_REVS = 3'h5;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int T_SETTLE_MS = 15;
  localparam int T_STEP_DD_NS = 2000;
  localparam int T_STEP_SD_NS = 4000;
  localparam int T_DIR_NS = 12000;
  localparam int STEP_DD_CYC = (T_STEP_DD_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_SD_CYC = (T_STEP_SD_NS * CLK_MHZ + 999) / 1000;
  localparam int DIR_CYC = (T_DIR_NS * CLK_MHZ + 999) / 1000;
  localparam int MS_CYC = CLK_MHZ * 1000;
  localparam int SETTLE_CYC = T_SETTLE_MS * MS_CYC;

  // step period in ms for the two rate bits
  function automatic int fdfc_step_ms(input logic [1:0] rate);
    case (rate)
      2'h0: fdfc_step_ms = 3;
      2'h1: fdfc_step_ms = 6;
      2'h2: fdfc_step_ms = 10;
      default: fdfc_step_ms = 15;
    endcase
  endfunction
endpackage

// ---- verilog/fdfc_crc16.sv ----
`timescale 1ns/10ps
module fdfc_crc16
  import fdfc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // byte feed
  input wire logic init,
  input wire logic feed,
  input wire logic [7:0] data_in,
  // running remainder
  output logic [15:0] crc
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // msb-first bytewise shift; init presets to ones and takes the mark byte at once
  always_comb begin
    logic [15:0] c;
    logic fb;
    c = init ? CRC_PRESET : crc_q;
    fb = 1'b0;
    if (init || feed) begin
      for (int i = 7; i >= 0; i--) begin
        fb = c[15] ^ data_in[i];
        c = {c[14:0], 1'b0};
        if (fb) begin
          c = c ^ CRC_POLY;
        end
      end
    end
    crc_d = c;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      crc_q <= CRC_PRESET;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;
endmodule

// ---- verilog/fdfc_core.sv ----
`timescale 1ns/10ps
// Functional notes
// - select lines pick status/command, track, sector, data
// - drive bus only on chip and output strobe
// - track register follows each step of restore and seek, of step in or out only with update flag
// - compare track register with recorded id track
// - compare sector register with recorded id sector
// - command write-only, status read-only
// - crc16 preset ones, mark through data
// - density select low means double density
// - read byte sets request, host read clears
// - request visible as status bit one after type 2 commands, index pulse after type 1
// - overwritten unread byte sets lost data
// - write byte moved sets request, host write clears
// - missing write byte writes zero, lost data
// - done interrupt on finish, cleared by status read or command write
// - rate bits choose step period
// - verify waits settle time, none in test
// - settle flag adds settle wait before transfer
// - step pulse width set by density
// - direction settles before first step pulse
// - verify checks id track and crc, five revolutions
// - master clear loads command and sector, restore
module fdfc_core
  import fdfc_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  // clock and master clear
  input wire logic clk,
  input wire logic reset_n,
  // host register port
  input wire logic cs_n,
  input wire logic output_strobe_n,
  input wire logic input_strobe_n,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] host_bus_lines_i,
  output logic [7:0] host_bus_lines_o,
  output logic host_bus_lines_oe,
  output logic byte_request,
  output logic done_irq,
  // drive control
  input wire logic density_select_n,
  input wire logic test_n,
  input wire logic mini_mode,
  input wire logic track00,
  input wire logic index_pulse,
  output logic step_pulse,
  output logic step_heading,
  // decoded disk byte stream
  input wire logic [7:0] rd_byte,
  input wire logic rd_valid,
  input wire logic rd_mark,
  input wire logic wr_due,
  output logic [7:0] wr_byte,
  output logic wr_strobe
);
  typedef enum logic [11:0] {
    S_IDLE = 12'h001, S_CHECK = 12'h002, S_DIR = 12'h004, S_PULSE = 12'h008,
    S_PERIOD = 12'h010, S_SETTLE = 12'h020, S_IDWAIT = 12'h040, S_IDFLD = 12'h080,
    S_IDCHK = 12'h100, S_DMWAIT = 12'h200, S_XFER = 12'h400, S_DONE = 12'h800
  } fdfc_state_e;

  fdfc_state_e st_q, st_d;
  logic [7:0] cmd_q, cmd_d, trk_q, trk_d, sec_q, sec_d, dat_q, dat_d, stat_q, stat_d;
  logic [7:0] id_trk_q, id_trk_d, id_sec_q, id_sec_d, out_q, out_d, wb_q, wb_d;
  logic [31:0] cnt_q, cnt_d;
  logic [10:0] fld_q, fld_d, nbytes_q, nbytes_d;
  logic [2:0] revs_q, revs_d;
  logic drq_q, drq_d, irq_q, irq_d, dir_q, dir_d, step_q, step_d, oe_q, oe_d;
  logic first_q, first_d, stepped_q, stepped_d, pend_q, pend_d, ws_q, ws_d;
  logic rd_prev_q, wr_prev_q, idx_prev_q;
  logic crc_init, crc_feed;
  logic [7:0] crc_byte;
  logic [15:0] crc;
  logic rd_act, rd_go, wr_go, idx_edge, type1, is_write;
  logic [7:0] status_view;

  // host strobes as levels in the clock domain, acted on at the leading edge
  assign rd_act = !cs_n && !output_strobe_n;
  assign rd_go = rd_act && !rd_prev_q;
  assign wr_go = !cs_n && !input_strobe_n && !wr_prev_q;
  assign idx_edge = index_pulse && !idx_prev_q;
  assign type1 = !cmd_q[7];
  assign is_write = cmd_q[CMD_WRITE_BIT];

  // busy and request bits are live; the rest is latched per command
  always_comb begin
    status_view = stat_q;
    status_view[ST_BUSY] = (st_q != S_IDLE);
    status_view[ST_DRQ] = type1 ? index_pulse : drq_q;
  end

  fdfc_crc16 u_crc (
    .clk(clk),
    .reset_n(reset_n),
    .init(crc_init),
    .feed(crc_feed),
    .data_in(crc_byte),
    .crc(crc)
  );

  // sequencer, register file and host port next state
  always_comb begin
    int per;
    st_d = st_q; cmd_d = cmd_q; trk_d = trk_q; sec_d = sec_q; dat_d = dat_q;
    stat_d = stat_q; id_trk_d = id_trk_q; id_sec_d = id_sec_q; wb_d = wb_q;
    cnt_d = cnt_q; fld_d = fld_q; nbytes_d = nbytes_q; revs_d = revs_q;
    drq_d = drq_q; irq_d = irq_q; dir_d = dir_q; step_d = step_q;
    first_d = first_q; stepped_d = stepped_q; pend_d = 1'b0; ws_d = 1'b0;
    crc_init = 1'b0; crc_feed = 1'b0; crc_byte = rd_byte;
    per = fdfc_step_ms(cmd_q[1:0]) * MS_CYCLES;
    if (mini_mode) begin
      per = per * 2;
    end
    // bus output register; driven only while chip and output strobe are low
    oe_d = rd_act;
    out_d = out_q;
    if (rd_act) begin
      unique case (reg_sel)
        SEL_CMD_STAT: out_d = status_view;
        SEL_TRACK: out_d = trk_q;
        SEL_SECTOR: out_d = sec_q;
        default: out_d = dat_q;
      endcase
    end
    // host clears come first so that hardware sets below win
    if (rd_go && reg_sel == SEL_CMD_STAT) begin
      irq_d = 1'b0;
    end
    if (rd_go && reg_sel == SEL_DATA) begin
      drq_d = 1'b0;
    end
    if (wr_go) begin
      unique case (reg_sel)
        SEL_CMD_STAT: begin
          irq_d = 1'b0;
          if (host_bus_lines_i[7:4] == OP_FORCE_INT) begin
            cmd_d = host_bus_lines_i;
            st_d = S_IDLE;
            step_d = 1'b0;
            irq_d = (host_bus_lines_i[3:0] != 4'h0);
          end else if (st_q == S_IDLE) begin
            cmd_d = host_bus_lines_i;
            pend_d = 1'b1;
          end
        end
        SEL_TRACK: trk_d = host_bus_lines_i;
        SEL_SECTOR: sec_d = host_bus_lines_i;
        default: begin
          dat_d = host_bus_lines_i;
          drq_d = 1'b0;
        end
      endcase
    end
    if (st_q != S_IDLE && cnt_q != 32'h0) begin
      cnt_d = cnt_q - 32'h1;
    end
    unique case (st_q)
      S_IDLE: begin
        if (pend_q) begin
          stat_d = 8'h00;
          drq_d = 1'b0;
          first_d = 1'b1;
          stepped_d = 1'b0;
          revs_d = 3'h0;
          if (type1) begin
            st_d = S_CHECK;
            if (cmd_q[7:5] == 3'h2) begin
              dir_d = 1'b1;
            end else if (cmd_q[7:5] == 3'h3) begin
              dir_d = 1'b0;
            end
          end else if (cmd_q[CMD_SETTLE_BIT]) begin
            st_d = S_SETTLE;
            cnt_d = 32'(SETTLE_CYCLES);
          end else begin
            st_d = S_IDWAIT;
          end
        end
      end
      S_CHECK: begin
        if ((cmd_q[7:4] == OP_RESTORE && track00) ||
            (cmd_q[7:4] == OP_SEEK && trk_q == dat_q) ||
            (cmd_q[7:5] != 3'h0 && stepped_q)) begin
          if (cmd_q[7:4] == OP_RESTORE) begin
            trk_d = 8'h00;
          end
          stat_d[ST_TRK0] = track00;
          if (!cmd_q[CMD_VERIFY_BIT]) begin
            st_d = S_DONE;
          end else if (!test_n) begin
            st_d = S_IDWAIT;
          end else begin
            st_d = S_SETTLE;
            cnt_d = 32'(SETTLE_CYCLES);
          end
        end else begin
          if (cmd_q[7:4] == OP_RESTORE) begin
            dir_d = 1'b0;
          end else if (cmd_q[7:4] == OP_SEEK) begin
            dir_d = (dat_q > trk_q);
          end
          st_d = S_DIR;
          // direction settle before the first pulse and after any reversal
          cnt_d = (first_q || dir_d != dir_q) ? 32'(DIR_CYC) : 32'h0;
        end
      end
      S_DIR: begin
        if (cnt_q == 32'h0) begin
          st_d = S_PULSE;
          step_d = 1'b1;
          cnt_d = density_select_n ? 32'(STEP_SD_CYC - 1) : 32'(STEP_DD_CYC - 1);
          if (cmd_q[7:5] == 3'h0 || cmd_q[CMD_UPDATE_BIT]) begin
            trk_d = dir_q ? trk_q + 8'h1 : trk_q - 8'h1;
          end
        end
      end
      S_PULSE: begin
        if (cnt_q == 32'h0) begin
          st_d = S_PERIOD;
          step_d = 1'b0;
          cnt_d = 32'(per);
        end
      end
      S_PERIOD: begin
        if (cnt_q == 32'h0) begin
          st_d = S_CHECK;
          first_d = 1'b0;
          stepped_d = 1'b1;
        end
      end
      S_SETTLE: begin
        if (cnt_q == 32'h0) begin
          st_d = S_IDWAIT;
        end
      end
      S_IDWAIT: begin
        if (idx_edge) begin
          revs_d = revs_q + 3'h1;
        end
        if (revs_q == VERIFY_REVS) begin
          stat_d[ST_SEEK] = 1'b1;
          st_d = S_DONE;
        end else if (rd_valid && rd_mark && rd_byte == MARK_ID) begin
          crc_init = 1'b1;
          fld_d = 11'h0;
          st_d = S_IDFLD;
        end
      end
      S_IDFLD: begin
        if (idx_edge) begin
          revs_d = revs_q + 3'h1;
        end
        if (rd_valid) begin
          crc_feed = 1'b1;
          fld_d = fld_q + 11'h1;
          if (fld_q == 11'h0) begin
            id_trk_d = rd_byte;
          end
          if (fld_q == 11'h2) begin
            id_sec_d = rd_byte;
          end
          if (fld_q == 11'h3) begin
            nbytes_d = SECTOR_BASE << rd_byte[1:0];
          end
          if (fld_q == ID_LAST) begin
            st_d = S_IDCHK;
          end
        end
      end
      S_IDCHK: begin
        if (crc == 16'h0 && id_trk_q == trk_q &&
            (type1 || id_sec_q == sec_q)) begin
          fld_d = 11'h0;
          if (type1) begin
            st_d = S_DONE;
          end else if (is_write) begin
            st_d = S_XFER;
            drq_d = 1'b1;
          end else begin
            st_d = S_DMWAIT;
          end
        end else begin
          st_d = S_IDWAIT;
        end
      end
      S_DMWAIT: begin
        if (rd_valid && rd_mark && rd_byte == MARK_DATA) begin
          crc_init = 1'b1;
          st_d = S_XFER;
        end
      end
      S_XFER: begin
        if (!is_write && rd_valid) begin
          crc_feed = 1'b1;
          fld_d = fld_q + 11'h1;
          if (fld_q < nbytes_q) begin
            dat_d = rd_byte;
            drq_d = 1'b1;
            if (drq_q && !(rd_go && reg_sel == SEL_DATA)) begin
              stat_d[ST_LOST] = 1'b1;
            end
          end else if (fld_q == nbytes_q + 11'h1) begin
            st_d = S_DONE;
            stat_d[ST_CRC] = (crc_d_zero(crc, rd_byte) == 1'b0);
          end
        end
        if (is_write && wr_due) begin
          ws_d = 1'b1;
          fld_d = fld_q + 11'h1;
          if (fld_q == 11'h0) begin
            wb_d = MARK_DATA;
            crc_init = 1'b1;
            crc_byte = MARK_DATA;
          end else if (fld_q <= nbytes_q) begin
            wb_d = drq_q ? 8'h00 : dat_q;
            crc_feed = 1'b1;
            crc_byte = wb_d;
            if (drq_q) begin
              stat_d[ST_LOST] = 1'b1;
            end
            drq_d = (fld_q != nbytes_q);
          end else if (fld_q == nbytes_q + 11'h1) begin
            wb_d = crc[15:8];
          end else begin
            wb_d = crc[7:0];
            st_d = S_DONE;
          end
        end
      end
      default: begin
        st_d = S_IDLE;
        drq_d = 1'b0;
        irq_d = 1'b1;
      end
    endcase
    // a force interrupt outranks the next state and step pulse the sequencer planned this cycle,
    // otherwise a step or transfer edge in the same cycle would swallow the abort
    if (wr_go && reg_sel == SEL_CMD_STAT && host_bus_lines_i[7:4] == OP_FORCE_INT) begin
      st_d = S_IDLE;
      step_d = 1'b0;
      pend_d = 1'b0;
    end
  end

  // second crc byte of a read is folded in by hand to judge the result at once
  function automatic logic crc_d_zero(input logic [15:0] c0, input logic [7:0] b);
    logic [15:0] c;
    c = c0;
    for (int i = 7; i >= 0; i--) begin
      c = c[15] ^ b[i] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    end
    crc_d_zero = (c == 16'h0);
  endfunction

  // registers; master clear loads command and sector and queues a restore
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      cmd_q <= CMD_RESET_VAL;
      sec_q <= SECTOR_RESET_VAL;
      pend_q <= 1'b1;
      trk_q <= TRACK_RESET_VAL; dat_q <= DATA_RESET_VAL; stat_q <= 8'h00;
      id_trk_q <= 8'h00; id_sec_q <= 8'h00; out_q <= 8'h00; wb_q <= 8'h00;
      cnt_q <= 32'h0; fld_q <= 11'h0; nbytes_q <= SECTOR_BASE; revs_q <= 3'h0;
      drq_q <= 1'b0; irq_q <= 1'b0; dir_q <= 1'b0; step_q <= 1'b0; oe_q <= 1'b0;
      first_q <= 1'b1; stepped_q <= 1'b0; ws_q <= 1'b0;
      rd_prev_q <= 1'b0; wr_prev_q <= 1'b0; idx_prev_q <= 1'b0;
    end else begin
      st_q <= st_d; cmd_q <= cmd_d; sec_q <= sec_d; pend_q <= pend_d;
      trk_q <= trk_d; dat_q <= dat_d; stat_q <= stat_d;
      id_trk_q <= id_trk_d; id_sec_q <= id_sec_d; out_q <= out_d; wb_q <= wb_d;
      cnt_q <= cnt_d; fld_q <= fld_d; nbytes_q <= nbytes_d; revs_q <= revs_d;
      drq_q <= drq_d; irq_q <= irq_d; dir_q <= dir_d; step_q <= step_d; oe_q <= oe_d;
      first_q <= first_d; stepped_q <= stepped_d; ws_q <= ws_d;
      rd_prev_q <= rd_act; wr_prev_q <= !cs_n && !input_strobe_n;
      idx_prev_q <= index_pulse;
    end
  end

  assign host_bus_lines_o = out_q;
  assign host_bus_lines_oe = oe_q;
  assign byte_request = drq_q;
  assign done_irq = irq_q;
  assign step_pulse = step_q;
  assign step_heading = dir_q;
  assign wr_byte = wb_q;
  assign wr_strobe = ws_q;

  // checking helpers: step width and direction age
  logic [31:0] pw_q, dage_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pw_q <= 32'h0;
      dage_q <= 32'h0;
    end else begin
      pw_q <= step_q ? pw_q + 32'h1 : 32'h0;
      dage_q <= (dir_d != dir_q) ? 32'h0 : dage_q + 32'h1;
    end
  end

  sequence s_data_read;
    rd_go && reg_sel == SEL_DATA;
  endsequence

  a_bus_drive: assert property (@(posedge clk) disable iff (!reset_n)
    host_bus_lines_oe == $past(!cs_n && !output_strobe_n)) else $error("bus enable wrong");
  a_status_read: assert property (@(posedge clk) disable iff (!reset_n)
    rd_act && reg_sel == SEL_CMD_STAT |=> host_bus_lines_o == $past(status_view))
    else $error("status not presented");
  a_track_step: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(step_pulse) && (cmd_q[7:5] == 3'h0 || cmd_q[CMD_UPDATE_BIT]) |->
    trk_q == (dir_q ? $past(trk_q) + 8'h1 : $past(trk_q) - 8'h1)) else $error("track not stepped");
  a_drq_clear: assert property (@(posedge clk) disable iff (!reset_n)
    s_data_read and st_q != S_XFER and st_q != S_IDCHK |=> !byte_request)
    else $error("request not cleared");
  a_lost_data: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == S_XFER && !is_write && rd_valid && fld_q < nbytes_q && drq_q && !rd_go
    |=> stat_q[ST_LOST] && byte_request) else $error("lost data missed");
  a_write_zero: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == S_XFER && is_write && wr_due && fld_q != 11'h0 && fld_q <= nbytes_q && drq_q
    |=> wr_strobe && wr_byte == 8'h00 && stat_q[ST_LOST]) else $error("zero byte missed");
  a_irq_done: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == S_DONE |=> done_irq && st_q == S_IDLE) else $error("no done interrupt");
  a_step_width: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(step_pulse) && st_q == S_PERIOD |->
    $past(pw_q) == 32'(density_select_n ? STEP_SD_CYC - 1 : STEP_DD_CYC - 1))
    else $error("step width wrong");
  a_dir_setup: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(step_pulse) && $past(first_q) |-> dage_q >= 32'(DIR_CYC)) else $error("direction late");
  a_reset_load: assert property (@(posedge clk)
    !reset_n |=> cmd_q == CMD_RESET_VAL && sec_q == SECTOR_RESET_VAL && pend_q)
    else $error("reset load wrong");
endmodule

// ---- verif/fdfc_drive_model.sv ----
`timescale 1ns/10ps
// stepper drive: moves one track per step pulse, reports track zero and index
module fdfc_drive_model #(
  parameter int START_CYL = 3,
  parameter int REV_CYC = 4000
) (
  // clock
  input wire logic clk,
  // drive pins
  input wire logic step_pulse,
  input wire logic step_heading,
  output logic track00,
  output logic index_pulse,
  // head position for the bench
  output int cyl
);
  int rev_cnt = 0;
  logic step_prev = 1'b0;
  initial cyl = START_CYL;
  // heading sampled at the rising edge of each pulse
  always @(posedge clk) begin
    step_prev <= step_pulse;
    if (step_pulse && !step_prev) cyl <= step_heading ? cyl + 1 : cyl - 1;
    rev_cnt <= (rev_cnt == REV_CYC - 1) ? 0 : rev_cnt + 1;
  end
  // short index mark once per revolution
  assign index_pulse = rev_cnt < 8;
  assign track00 = cyl == 0;
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import fdfc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n = 1'b1;
  logic output_strobe_n = 1'b1;
  logic input_strobe_n = 1'b1;
  logic [1:0] reg_sel = 2'h0;
  logic [7:0] bus_i = 8'h00;
  logic density_select_n = 1'b0;
  logic test_n = 1'b1;
  logic mini_mode = 1'b0;
  logic [7:0] bus_o;
  logic [7:0] rd;
  logic [7:0] rd_byte = 8'h00;
  logic rd_valid = 1'b0;
  logic rd_mark = 1'b0;
  logic bus_oe, byte_request, done_irq, step_pulse, step_heading, track00, index_pulse;
  logic hd_prev = 1'b0;
  logic st_prev = 1'b0;
  int cyl;
  int failures = 0;
  int samples_checked = 0;
  int width = 0;
  int hi_cnt = 0;
  int dir_age = 0;
  int min_lead = 0;

  always #2.5 clk = ~clk;

  // short ms so step periods outlast the 400/800 cycle pulses
  fdfc_core #(.MS_CYCLES(200), .SETTLE_CYCLES(20)) i_dut (
    .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .output_strobe_n(output_strobe_n),
    .input_strobe_n(input_strobe_n), .reg_sel(reg_sel), .host_bus_lines_i(bus_i),
    .host_bus_lines_o(bus_o), .host_bus_lines_oe(bus_oe), .byte_request(byte_request),
    .done_irq(done_irq), .density_select_n(density_select_n), .test_n(test_n),
    .mini_mode(mini_mode), .track00(track00), .index_pulse(index_pulse),
    .step_pulse(step_pulse), .step_heading(step_heading), .rd_byte(rd_byte),
    .rd_valid(rd_valid), .rd_mark(rd_mark), .wr_due(1'b0), .wr_byte(), .wr_strobe());

  fdfc_drive_model i_drive (.clk(clk), .step_pulse(step_pulse),
    .step_heading(step_heading), .track00(track00), .index_pulse(index_pulse), .cyl(cyl));

  // pulse width and heading lead, measured in clock cycles
  always @(posedge clk) begin
    hd_prev <= step_heading;
    st_prev <= step_pulse;
    dir_age <= (step_heading !== hd_prev) ? 0 : dir_age + 1;
    hi_cnt <= step_pulse ? hi_cnt + 1 : 0;
    if (!step_pulse && st_prev) width <= hi_cnt;
    if (step_pulse && !st_prev && dir_age < min_lead) min_lead <= dir_age;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one write strobe, one cycle low
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    input_strobe_n = 1'b0;
    reg_sel = a;
    bus_i = d;
    @(negedge clk);
    cs_n = 1'b1;
    input_strobe_n = 1'b1;
    @(negedge clk);
  endtask

  // read answer lands one cycle after the strobe is seen
  task automatic rdreg(input logic [1:0] a);
    @(negedge clk);
    cs_n = 1'b0;
    output_strobe_n = 1'b0;
    reg_sel = a;
    repeat (2) @(negedge clk);
    rd = bus_o;
    check("bus enable", bus_oe, 1'b1);
    cs_n = 1'b1;
    output_strobe_n = 1'b1;
    repeat (2) @(negedge clk);
    check("bus release", bus_oe, 1'b0);
  endtask

  // bounded wait; the host touches no register until the command ends
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (done_irq !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("irq set", done_irq, 1'b1);
    if (n >= lim) report_and_stop();
  endtask

  // bench's own msb-first crc, preset ones, x^16+x^12+x^5+1
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // one decoded disk byte, valid for a single cycle
  task automatic disk_byte(input logic [7:0] b, input logic m);
    @(negedge clk);
    rd_byte = b;
    rd_mark = m;
    rd_valid = 1'b1;
    @(negedge clk);
    rd_valid = 1'b0;
    rd_mark = 1'b0;
  endtask

  // id field: mark, track, side 0, sector 1, length code 0, good crc
  task automatic send_id(input logic [7:0] trk);
    logic [15:0] c;
    c = crc_upd(CRC_PRESET, MARK_ID);
    c = crc_upd(c, trk);
    c = crc_upd(c, 8'h00);
    c = crc_upd(c, 8'h01);
    c = crc_upd(c, 8'h00);
    disk_byte(MARK_ID, 1'b1);
    disk_byte(trk, 1'b0);
    disk_byte(8'h00, 1'b0);
    disk_byte(8'h01, 1'b0);
    disk_byte(8'h00, 1'b0);
    disk_byte(c[15:8], 1'b0);
    disk_byte(c[7:0], 1'b0);
  endtask

  task automatic t_restore();
    wait_irq(20000);
    check("drive at zero", cyl, 0);
    check("heading out", step_heading, 1'b0);
    check("dd width", width, STEP_DD_CYC);
    rdreg(SEL_TRACK);
    check("track", rd, 8'h00);
    rdreg(SEL_SECTOR);
    check("sector reset", rd, SECTOR_RESET_VAL);
    rdreg(SEL_CMD_STAT);
    check("status", rd & 8'he1, 8'h00);
    check("irq clr read", done_irq, 1'b0);
    $display("done restore");
  endtask

  task automatic t_seek_in();
    min_lead = 1000000;
    wr(SEL_DATA, 8'h02);
    wr(SEL_CMD_STAT, 8'h10);
    repeat (1200) @(negedge clk);
    rdreg(SEL_CMD_STAT);
    check("busy", rd[ST_BUSY], 1'b1);
    wait_irq(6000);
    check("drive cyl", cyl, 2);
    check("heading in", step_heading, 1'b1);
    check("lead", (min_lead + 1) >= DIR_CYC, 1'b1);
    check("dd width", width, STEP_DD_CYC);
    rdreg(SEL_TRACK);
    check("track up", rd, 8'h02);
    $display("done seek in");
  endtask

  task automatic t_seek_out_sd();
    density_select_n = 1'b1;
    wr(SEL_DATA, 8'h00);
    wr(SEL_CMD_STAT, 8'h13);
    wait_irq(14000);
    check("drive cyl", cyl, 0);
    check("heading out", step_heading, 1'b0);
    check("sd width", width, STEP_SD_CYC);
    rdreg(SEL_TRACK);
    check("track down", rd, 8'h00);
    density_select_n = 1'b0;
    $display("done seek out");
  endtask

  task automatic t_force();
    rdreg(SEL_CMD_STAT);
    check("irq before force", done_irq, 1'b0);
    wr(SEL_CMD_STAT, 8'hd8);
    wait_irq(100);
    wr(SEL_CMD_STAT, 8'hd0);
    check("irq clr write", done_irq, 1'b0);
    $display("done force");
  endtask

  task automatic t_regs();
    wr(SEL_TRACK, 8'h5a);
    wr(SEL_SECTOR, 8'ha5);
    wr(SEL_DATA, 8'h3c);
    rdreg(SEL_TRACK);
    check("track rw", rd, 8'h5a);
    rdreg(SEL_SECTOR);
    check("sector rw", rd, 8'ha5);
    rdreg(SEL_DATA);
    check("data rw", rd, 8'h3c);
    $display("done regs");
  endtask

  // seek in place with verify: wrong track ignored, right one ends, none times out
  task automatic t_verify();
    test_n = 1'b0;
    wr(SEL_CMD_STAT, 8'h14);
    repeat (4) @(negedge clk);
    send_id(8'h07);
    repeat (4) @(negedge clk);
    check("wrong track", done_irq, 1'b0);
    send_id(8'h00);
    wait_irq(50);
    rdreg(SEL_CMD_STAT);
    check("verify ok", rd & 8'h19, 8'h00);
    wr(SEL_CMD_STAT, 8'h14);
    wait_irq(25000);
    rdreg(SEL_CMD_STAT);
    check("seek error", rd & 8'h19, 8'h10);
    test_n = 1'b1;
    $display("done verify");
  endtask

  // sector read: first byte taken by the host, the rest left to overrun
  task automatic t_read_lost();
    logic [15:0] c;
    c = crc_upd(CRC_PRESET, MARK_DATA);
    wr(SEL_CMD_STAT, 8'h80);
    repeat (4) @(negedge clk);
    send_id(8'h00);
    disk_byte(MARK_DATA, 1'b1);
    for (int i = 0; i < 128; i++) begin
      disk_byte(8'(i), 1'b0);
      c = crc_upd(c, 8'(i));
      if (i == 0) begin
        check("read request", byte_request, 1'b1);
        rdreg(SEL_DATA);
        check("first byte", rd, 8'h00);
        check("request cleared", byte_request, 1'b0);
      end
    end
    disk_byte(c[15:8], 1'b0);
    disk_byte(c[7:0], 1'b0);
    wait_irq(50);
    rdreg(SEL_CMD_STAT);
    check("lost status", rd & 8'h1f, 8'h04);
    rdreg(SEL_DATA);
    check("last byte", rd, 8'h7f);
    $display("done read lost");
  endtask

  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    t_restore();
    t_seek_in();
    t_seek_out_sd();
    t_force();
    t_verify();
    t_read_lost();
    t_regs();
    report_and_stop();
  end
endmodule
